// file: rtl/sdtc_ecc.v
// Per-word single-correct double-detect code, encode and check
`default_nettype none
module sdtc_ecc #(
  parameter DW = 64
) (
  input wire [DW-1:0] data_i,
  input wire [7:0] chk_i,
  output wire [7:0] code_o,
  output reg [DW-1:0] fixed_o,
  output wire corr_o,
  output wire unc_o
);
  reg [6:0] hp;
  reg [6:0] pos;
  reg [6:0] pos2;
  integer i;
  integer k;
  wire [6:0] syn = hp ^ chk_i[6:0];
  wire pe = (^data_i) ^ (^chk_i);

  // Data bits sit on non-power-of-two positions, check bits on the rest
  always @* begin
    pos = 7'H3;
    hp = 7'H0;
    for (i = 0; i < DW; i = i + 1) begin
      if ((pos & (pos - 7'H1)) == 7'H0)
        pos = pos + 7'H1;
      if (data_i[i])
        hp = hp ^ pos;
      pos = pos + 7'H1;
    end
  end

  assign code_o = {(^data_i) ^ (^hp), hp};
  assign corr_o = (syn != 7'H0) & pe;
  assign unc_o = (syn != 7'H0) & ~pe;

  always @* begin
    pos2 = 7'H3;
    fixed_o = data_i;
    for (k = 0; k < DW; k = k + 1) begin
      if ((pos2 & (pos2 - 7'H1)) == 7'H0)
        pos2 = pos2 + 7'H1;
      if (corr_o && (syn == pos2))
        fixed_o[k] = ~data_i[k];
      pos2 = pos2 + 7'H1;
    end
  end
endmodule // sdtc_ecc
`default_nettype wire

// file: rtl/sdtc_fifo.v
// Small valid/ready FIFO on the host write stream
`default_nettype none
module sdtc_fifo #(
  parameter DW = 64,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire in_valid_i,
  input wire [DW-1:0] in_data_i,
  output reg in_ready_o,
  output reg out_valid_o,
  output wire [DW-1:0] out_data_o,
  input wire out_ready_i
);
  reg [DW-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0] cnt;
  reg [AW:0] next_cnt;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  assign out_data_o = mem[rp];

  always @* begin
    next_cnt = cnt;
    if (push & ~pop)
      next_cnt = cnt + {{AW{1'H0}}, 1'H1};
    else if (pop & ~push)
      next_cnt = cnt - {{AW{1'H0}}, 1'H1};
  end

  always @(posedge clk_sys_i) begin
    if (push)
      mem[wp] <= in_data_i;
  end

  // Flags registered so ready never depends on the sink combinationally
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wp <= {AW{1'H0}};
      rp <= {AW{1'H0}};
      cnt <= {(AW+1){1'H0}};
      in_ready_o <= 1'H0;
      out_valid_o <= 1'H0;
    end else begin
      if (push)
        wp <= wp + {{(AW-1){1'H0}}, 1'H1};
      if (pop)
        rp <= rp + {{(AW-1){1'H0}}, 1'H1};
      cnt <= next_cnt;
      in_ready_o <= (next_cnt != DEPTH[AW:0]);
      out_valid_o <= (next_cnt != {(AW+1){1'H0}});
    end
  end
endmodule // sdtc_fifo
`default_nettype wire

// file: rtl/sdtc_regs.vh
// Constants of the striped disk track controller
`ifndef SDTC_REGS_VH
`define SDTC_REGS_VH
`define SDTC_DW 64
`define SDTC_CW 8
`define SDTC_HW 7
`define SDTC_BLK_WORDS 10'H200
`define SDTC_BLK_LAST 10'H1FF
`define SDTC_TRK_SECT 7'H30
`define SDTC_TRK_WORDS 24576
`define SDTC_SPINDLES 8
`define SDTC_ZERO_WORDS 2'H2
`define SDTC_FIFO_DEPTH 16
`define SDTC_FIFO_AW 4
`define SDTC_OP_READ 2'H0
`define SDTC_OP_WRITE 2'H1
`define SDTC_OP_FMT 2'H2
`define SDTC_OP_CTRL 2'H3
`endif

// file: rtl/sdtc_track_ctrl.v
// Disk control unit: striping, track buffer, code and defect handling
`include "sdtc_regs.vh"
`default_nettype none
module sdtc_track_ctrl (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire cmd_valid_i,
  input wire [1:0] cmd_op_i,
  input wire cmd_drive_i,
  input wire [5:0] cmd_sector_i,
  input wire [5:0] cmd_count_i,
  input wire cmd_flaw_i,
  input wire [8:0] cmd_defect_i,
  input wire [7:0] cmd_func_i,
  output reg cmd_ready_o,
  output reg done_o,
  output reg stat_bad_o,
  output reg stat_corr_o,
  output reg stat_unc_o,
  output reg [7:0] stat_drive_o,
  input wire hw_valid_i,
  input wire [`SDTC_DW-1:0] hw_data_i,
  output wire hw_ready_o,
  output reg hr_valid_o,
  output reg [`SDTC_DW-1:0] hr_data_o,
  input wire hr_ready_i,
  output reg [`SDTC_SPINDLES-1:0] dk_sel_o,
  output reg [3:0] dk_psec_o,
  output reg dk_start_o,
  output reg dk_wr_o,
  output reg dk_wvalid_o,
  output reg [`SDTC_DW-1:0] dk_wdata_o,
  output reg [`SDTC_CW-1:0] dk_wecc_o,
  input wire dk_wready_i,
  input wire dk_rvalid_i,
  input wire [`SDTC_DW-1:0] dk_rdata_i,
  input wire [`SDTC_CW-1:0] dk_recc_i,
  output reg dk_func_valid_o,
  output reg [7:0] dk_func_o,
  input wire [8*`SDTC_SPINDLES-1:0] dk_status_i,
  output reg dk_id_wr_o,
  output reg [9:0] dk_id_o
);
  localparam S_IDLE = 4'H0, S_HFILL = 4'H1, S_DSEC = 4'H2;
  localparam S_DXFR = 4'H3, S_HOUT = 4'H4, S_FMT = 4'H5;
  localparam S_CTL = 4'H6, S_CST = 4'H7, S_DONE = 4'H8;
  reg [`SDTC_DW-1:0] trk_mem [0:`SDTC_TRK_WORDS-1];
  reg [3:0] state;
  reg [1:0] op, zcnt;
  reg drv, flaw, mem_we;
  reg [5:0] sec, sec0, rem, cnt0;
  reg [8:0] defect;
  reg [9:0] wcnt;
  reg [7:0] func;
  reg [14:0] mem_wa;
  reg [`SDTC_DW-1:0] mem_wd;
  wire [5:0] cnt_eff;
  wire [6:0] sec_end;
  wire [14:0] buf_a;
  wire [`SDTC_DW-1:0] buf_d, rd_fixed, fifo_data;
  wire [`SDTC_CW-1:0] enc_code;
  wire rd_corr, rd_unc, fifo_valid, fifo_take, in_zero, blk_end, last_word;
  // a zero count still moves one whole block
  assign cnt_eff = (cmd_count_i == 6'H0) ? 6'H1 : cmd_count_i;
  assign sec_end = {1'H0, cmd_sector_i} + {1'H0, cnt_eff};
  assign buf_a = {sec, wcnt[8:0]};
  assign buf_d = trk_mem[buf_a];
  assign fifo_take = (state == S_HFILL);
  // zero field sits just before word at defect address
  assign in_zero = flaw && (wcnt == {1'H0, defect}) &&
                   (zcnt != `SDTC_ZERO_WORDS);
  assign blk_end = (wcnt == `SDTC_BLK_WORDS);
  assign last_word = (wcnt == `SDTC_BLK_LAST);
  sdtc_fifo #(.DW(`SDTC_DW), .DEPTH(`SDTC_FIFO_DEPTH),
    .AW(`SDTC_FIFO_AW)) u_wfifo (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(hw_valid_i),
    .in_data_i(hw_data_i),
    .in_ready_o(hw_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_take)
  );
  sdtc_ecc #(.DW(`SDTC_DW)) u_enc (
    .data_i(buf_d), .chk_i(8'H00),
    .code_o(enc_code),
    .fixed_o(), .corr_o(), .unc_o()
  );
  sdtc_ecc #(.DW(`SDTC_DW)) u_chk (
    .data_i(dk_rdata_i), .chk_i(dk_recc_i),
    .code_o(),
    .fixed_o(rd_fixed),
    .corr_o(rd_corr),
    .unc_o(rd_unc)
  );
  always @* begin
    mem_we = 1'H0;
    mem_wa = buf_a;
    mem_wd = fifo_data;
    if (state == S_HFILL) begin
      mem_we = fifo_valid;
    end else if (state == S_DXFR && !dk_wr_o) begin
      // zero field words never reach the buffer
      mem_we = dk_rvalid_i && !in_zero && !blk_end;
      mem_wd = rd_fixed;
    end
  end
  always @(posedge clk_sys_i) begin
    if (mem_we)
      trk_mem[mem_wa] <= mem_wd;
  end
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= S_IDLE;
      op <= `SDTC_OP_READ;
      drv <= 1'H0;
      sec <= 6'H0;
      sec0 <= 6'H0;
      rem <= 6'H0;
      cnt0 <= 6'H0;
      flaw <= 1'H0;
      defect <= 9'H000;
      wcnt <= 10'H000;
      zcnt <= 2'H0;
      func <= 8'H00;
      cmd_ready_o <= 1'H1;
      done_o <= 1'H0;
      stat_bad_o <= 1'H0;
      stat_corr_o <= 1'H0;
      stat_unc_o <= 1'H0;
      stat_drive_o <= 8'H00;
      hr_valid_o <= 1'H0;
      hr_data_o <= {`SDTC_DW{1'H0}};
      dk_sel_o <= {`SDTC_SPINDLES{1'H0}};
      dk_psec_o <= 4'H0;
      dk_start_o <= 1'H0;
      dk_wr_o <= 1'H0;
      dk_wvalid_o <= 1'H0;
      dk_wdata_o <= {`SDTC_DW{1'H0}};
      dk_wecc_o <= {`SDTC_CW{1'H0}};
      dk_func_valid_o <= 1'H0;
      dk_func_o <= 8'H00;
      dk_id_wr_o <= 1'H0;
      dk_id_o <= 10'H000;
    end else begin
      done_o <= 1'H0;
      dk_start_o <= 1'H0;
      dk_wvalid_o <= 1'H0;
      dk_func_valid_o <= 1'H0;
      dk_id_wr_o <= 1'H0;
      case (state)
        S_IDLE: begin
          // a new command only while nothing is in flight
          if (cmd_valid_i) begin
            cmd_ready_o <= 1'H0;
            op <= cmd_op_i;
            drv <= cmd_drive_i;
            sec <= cmd_sector_i;
            sec0 <= cmd_sector_i;
            rem <= cnt_eff;
            cnt0 <= cnt_eff;
            flaw <= cmd_flaw_i;
            defect <= cmd_defect_i;
            func <= cmd_func_i;
            wcnt <= 10'H000;
            stat_bad_o <= 1'H0;
            stat_corr_o <= 1'H0;
            stat_unc_o <= 1'H0;
            stat_drive_o <= 8'H00;
            // chains must stay inside the 48-sector track
            if ({1'H0, cmd_sector_i} >= `SDTC_TRK_SECT ||
                sec_end > `SDTC_TRK_SECT) begin
              stat_bad_o <= 1'H1;
              state <= S_DONE;
            end else if (cmd_op_i == `SDTC_OP_WRITE)
              state <= S_HFILL;
            else if (cmd_op_i == `SDTC_OP_READ)
              state <= S_DSEC;
            else if (cmd_op_i == `SDTC_OP_FMT)
              state <= S_FMT;
            else
              state <= S_CTL;
          end
        end
        S_HFILL: begin
          if (fifo_valid) begin
            wcnt <= wcnt + 10'H001;
            if (last_word) begin
              wcnt <= 10'H000;
              if (rem == 6'H1) begin
                sec <= sec0;
                rem <= cnt0;
                state <= S_DSEC;
              end else begin
                sec <= sec + 6'H1;
                rem <= rem - 6'H1;
              end
            end
          end
        end
        S_DSEC: begin
          // spindle from low sector bits, drive picks the group
          dk_sel_o <= {{(`SDTC_SPINDLES-1){1'H0}}, 1'H1} << {drv, sec[1:0]};
          dk_psec_o <= sec[5:2];
          dk_wr_o <= (op == `SDTC_OP_WRITE);
          dk_start_o <= 1'H1;
          wcnt <= 10'H000;
          zcnt <= 2'H0;
          state <= S_DXFR;
        end
        S_DXFR: begin
          if (dk_wr_o) begin
            if (!blk_end && dk_wready_i) begin
              dk_wvalid_o <= 1'H1;
              // zero field carries an all-zero code word too
              if (in_zero) begin
                zcnt <= zcnt + 2'H1;
                dk_wdata_o <= {`SDTC_DW{1'H0}};
                dk_wecc_o <= {`SDTC_CW{1'H0}};
              end else begin
                // code travels with each word of the block
                dk_wdata_o <= buf_d;
                dk_wecc_o <= enc_code;
                wcnt <= wcnt + 10'H001;
              end
            end
          end else begin
            if (!blk_end && dk_rvalid_i) begin
              if (in_zero)
                zcnt <= zcnt + 2'H1;
              else begin
                wcnt <= wcnt + 10'H001;
                // flags kept until the next command
                if (rd_corr)
                  stat_corr_o <= 1'H1;
                if (rd_unc)
                  stat_unc_o <= 1'H1;
              end
            end
          end
          // chain on to the next sector or finish
          if (blk_end) begin
            wcnt <= 10'H000;
            if (rem == 6'H1) begin
              dk_sel_o <= {`SDTC_SPINDLES{1'H0}};
              if (dk_wr_o)
                state <= S_DONE;
              else begin
                sec <= sec0;
                rem <= cnt0;
                state <= S_HOUT;
              end
            end else begin
              sec <= sec + 6'H1;
              rem <= rem - 6'H1;
              state <= S_DSEC;
            end
          end
        end
        S_HOUT: begin
          if (!hr_valid_o || hr_ready_i) begin
            if (rem != 6'H0) begin
              hr_valid_o <= 1'H1;
              hr_data_o <= buf_d;
              wcnt <= wcnt + 10'H001;
              if (last_word) begin
                wcnt <= 10'H000;
                sec <= sec + 6'H1;
                rem <= rem - 6'H1;
              end
            end else begin
              hr_valid_o <= 1'H0;
              state <= S_DONE;
            end
          end
        end
        S_FMT: begin
          // defect parameter goes into the sector identifier
          dk_sel_o <= {{(`SDTC_SPINDLES-1){1'H0}}, 1'H1} << {drv, sec[1:0]};
          dk_psec_o <= sec[5:2];
          dk_id_o <= {flaw, defect};
          dk_id_wr_o <= 1'H1;
          state <= S_DONE;
        end
        S_CTL: begin
          // function goes to the addressed spindle only
          dk_sel_o <= {{(`SDTC_SPINDLES-1){1'H0}}, 1'H1} << {drv, sec[1:0]};
          dk_func_o <= func;
          dk_func_valid_o <= 1'H1;
          state <= S_CST;
        end
        S_CST: begin
          // status of that spindle back to the adapter
          stat_drive_o <= dk_status_i[{drv, sec[1:0], 3'H0} +: 8];
          state <= S_DONE;
        end
        S_DONE: begin
          dk_sel_o <= {`SDTC_SPINDLES{1'H0}};
          done_o <= 1'H1;
          cmd_ready_o <= 1'H1;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // sdtc_track_ctrl
`default_nettype wire

// file: tb/sdtc_disk_model.sv
// Behavioural spindles behind the controller disk port
`default_nettype none
module sdtc_disk_model (
  input wire logic clk_sys_i,
  input wire logic slow_i,
  input wire logic [1:0] flips_i,
  input wire logic [7:0] dk_sel_o,
  input wire logic [3:0] dk_psec_o,
  input wire logic dk_start_o,
  input wire logic dk_wr_o,
  input wire logic dk_wvalid_o,
  input wire logic [63:0] dk_wdata_o,
  input wire logic [7:0] dk_wecc_o,
  output logic dk_wready_i,
  output logic dk_rvalid_i,
  output logic [63:0] dk_rdata_i,
  output logic [7:0] dk_recc_i,
  output logic [63:0] dk_status_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [71:0] mem [int];
  int cnt [int];
  int key = 0, wi = 0, ri = 0, rn = 0;
  logic [71:0] w;
  initial begin
    dk_wready_i = 0;
    dk_rvalid_i = 0;
    dk_rdata_i = 64'H0;
    dk_recc_i = 8'H0;
    for (int n = 0; n < 8; n++)
      dk_status_i[8*n+:8] = 8'H50 + n[7:0];
  end
  always @(posedge clk_sys_i) begin
    dk_wready_i <= !slow_i || $urandom_range(1) == 1;
    if (dk_start_o) begin
      key = $clog2(dk_sel_o) * 16 + dk_psec_o;
      wi = 0;
      ri = 0;
      rn = dk_wr_o ? 0 : cnt[key];
    end
    if (dk_wvalid_o) begin
      mem[key * 1024 + wi] = {dk_wecc_o, dk_wdata_o};
      wi++;
      cnt[key] = wi;
    end
    if (rn > 0 && !dk_start_o && (!slow_i || $urandom_range(1) == 1)) begin
      w = mem[key * 1024 + ri];
      if (ri == 7)
        w[1:0] = w[1:0] ^ (flips_i == 2'H2 ? 2'H3 : {1'H0, flips_i[0]});
      dk_rvalid_i <= 1'H1;
      {dk_recc_i, dk_rdata_i} <= w;
      ri++;
      rn--;
    end else begin
      // Idle bus must not look like stale data
      dk_rvalid_i <= 1'H0;
      dk_rdata_i <= ~dk_rdata_i;
    end
  end
endmodule // sdtc_disk_model
`default_nettype wire

// file: tb/sdtc_props.sv
// Port assertions for the striped track controller
`default_nettype none
module sdtc_props (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic [5:0] cmd_sector_i,
  input wire logic [5:0] cmd_count_i,
  input wire logic [7:0] cmd_func_i,
  input wire logic cmd_ready_o,
  input wire logic done_o,
  input wire logic stat_bad_o,
  input wire logic [7:0] dk_sel_o,
  input wire logic [3:0] dk_psec_o,
  input wire logic dk_start_o,
  input wire logic dk_wvalid_o,
  input wire logic [63:0] dk_wdata_o,
  input wire logic [7:0] dk_wecc_o,
  input wire logic dk_func_valid_o,
  input wire logic [7:0] dk_func_o,
  input wire logic dk_id_wr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  wire logic take = cmd_valid_i && cmd_ready_o;
  wire logic [6:0] last = cmd_sector_i +
    ((cmd_count_i == 6'H0) ? 6'H1 : cmd_count_i);
  wire logic good = last <= 7'H30;
  property p_ctl;
    take && good && cmd_op_i == 2'H3 |-> ##2 dk_func_valid_o
      && dk_func_o == $past(cmd_func_i, 2) ##2 done_o && !stat_bad_o;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control walk wrong");
  property p_bad;
    take && !good |-> ##2 done_o && stat_bad_o;
  endproperty
  a_bad: assert property (p_bad) else $error("range not refused");
  property p_fmt;
    take && good && cmd_op_i == 2'H2 |-> ##[1:2] dk_id_wr_o ##[0:1] done_o;
  endproperty
  a_fmt: assert property (p_fmt) else $error("no id write");
  property p_sel;
    dk_start_o |-> $onehot(dk_sel_o) && dk_psec_o < 4'HC;
  endproperty
  a_sel: assert property (p_sel) else $error("bad spindle");
  property p_ecc;
    dk_wvalid_o |-> (^{dk_wdata_o, dk_wecc_o}) == 1'H0;
  endproperty
  a_ecc: assert property (p_ecc) else $error("code parity");
  property p_done;
    done_o |-> cmd_ready_o && !$past(cmd_ready_o) ##1 !done_o;
  endproperty
  a_done: assert property (p_done) else $error("done handshake");
  property p_busy;
    take |=> !cmd_ready_o;
  endproperty
  a_busy: assert property (p_busy) else $error("ready after take");
  property p_start;
    dk_start_o |=> !dk_start_o [*8];
  endproperty
  a_start: assert property (p_start) else $error("sector overlap");
  c_ctl: cover property (dk_func_valid_o);
  c_bad: cover property (done_o && stat_bad_o);
  c_zero: cover property (dk_wvalid_o && dk_wdata_o == 64'H0);
endmodule // sdtc_props
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench of the striped track controller
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 0, sys_rst_i = 1, cmd_valid_i = 0, cmd_drive_i = 0;
  logic cmd_flaw_i = 0, hw_valid_i = 0, hr_ready_i = 0, slow = 0;
  logic hw_took = 0;
  logic [1:0] cmd_op_i = 0, flips = 0;
  logic [5:0] cmd_sector_i = 0, cmd_count_i = 0;
  logic [8:0] cmd_defect_i = 0;
  logic [7:0] cmd_func_i = 0;
  logic [63:0] hw_data_i = 0;
  wire logic cmd_ready_o, done_o, stat_bad_o, stat_corr_o, stat_unc_o;
  wire logic hw_ready_o, hr_valid_o, dk_start_o, dk_wr_o, dk_wvalid_o;
  wire logic dk_wready_i, dk_rvalid_i, dk_func_valid_o, dk_id_wr_o;
  wire logic [7:0] stat_drive_o, dk_sel_o, dk_wecc_o, dk_recc_i, dk_func_o;
  wire logic [63:0] hr_data_o, dk_wdata_o, dk_rdata_i, dk_status_i;
  wire logic [3:0] dk_psec_o;
  wire logic [9:0] dk_id_o;
  logic [64:0] dq [$];
  logic [15:0] sq [$], lq [$], iq [$];
  logic [63:0] wq [$], img [$];
  int error_cnt = 0, n_checks = 0, n_done = 0, wcnt = 0;
  sdtc_track_ctrl uut (.clk_sys_i, .sys_rst_i, .cmd_valid_i, .cmd_op_i,
    .cmd_drive_i, .cmd_sector_i, .cmd_count_i, .cmd_flaw_i, .cmd_defect_i,
    .cmd_func_i, .cmd_ready_o, .done_o, .stat_bad_o, .stat_corr_o,
    .stat_unc_o, .stat_drive_o, .hw_valid_i, .hw_data_i, .hw_ready_o,
    .hr_valid_o, .hr_data_o, .hr_ready_i, .dk_sel_o, .dk_psec_o, .dk_start_o,
    .dk_wr_o, .dk_wvalid_o, .dk_wdata_o, .dk_wecc_o, .dk_wready_i,
    .dk_rvalid_i, .dk_rdata_i, .dk_recc_i, .dk_func_valid_o, .dk_func_o,
    .dk_status_i, .dk_id_wr_o, .dk_id_o);
  sdtc_disk_model disk (.clk_sys_i, .slow_i(slow), .flips_i(flips),
    .dk_sel_o, .dk_psec_o, .dk_start_o, .dk_wr_o, .dk_wvalid_o, .dk_wdata_o,
    .dk_wecc_o, .dk_wready_i, .dk_rvalid_i, .dk_rdata_i, .dk_recc_i,
    .dk_status_i);
  initial forever #4 clk_sys_i = ~clk_sys_i;
  task automatic cmp_data(input logic [63:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_stat(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    hw_took <= hw_valid_i && hw_ready_o;
    if (hr_valid_o && hr_ready_i && (dq.size() == 0 || !dq[0][64]))
      cmp_data(hr_data_o, dq[0][63:0]);
    if (hr_valid_o && hr_ready_i)
      void'(dq.pop_front());
    if (done_o)
      cmp_stat({5'H0, stat_bad_o, stat_corr_o, stat_unc_o, stat_drive_o},
        sq.pop_front());
    if (done_o)
      n_done++;
    if (dk_start_o)
      cmp_stat({4'H0, dk_sel_o, dk_psec_o}, lq.pop_front());
    wcnt = dk_start_o ? 0 : wcnt + int'(dk_wvalid_o);
    if (dk_id_wr_o)
      cmp_stat({6'H0, dk_id_o}, iq.pop_front());
  end
  // Host side: hold each word until taken, random gaps and stalls
  always @(negedge clk_sys_i) begin
    hr_ready_i = $urandom_range(3) != 0;
    if (hw_took)
      void'(wq.pop_front());
    if (!hw_valid_i || hw_took) begin
      hw_valid_i = wq.size() > 0 && $urandom_range(3) != 0;
      hw_data_i = hw_valid_i ? wq[0] : ~hw_data_i;
    end
  end
  task automatic run_cmd(input logic [1:0] op, input logic drv,
      input logic [5:0] sec, cnt, input logic flaw, input logic [8:0] dfc,
      input logic [7:0] fn);
    int n;
    n = n_done;
    @(negedge clk_sys_i);
    while (!cmd_ready_o)
      @(negedge clk_sys_i);
    {cmd_op_i, cmd_drive_i, cmd_sector_i, cmd_count_i} = {op, drv, sec, cnt};
    {cmd_flaw_i, cmd_defect_i, cmd_func_i} = {flaw, dfc, fn};
    cmd_valid_i = 1;
    @(negedge clk_sys_i);
    cmd_valid_i = 0;
    for (int t = 0; t < 20000 && n_done == n; t++)
      @(negedge clk_sys_i);
    if (n_done == n) begin
      error_cnt++;
      complete_run;
    end
  endtask
  task automatic xfer(input logic wr, drv, input logic [5:0] sec, cnt,
      input logic flaw, input logic [8:0] dfc, input logic [1:0] f);
    logic [5:0] s;
    int ns;
    ns = (cnt == 6'H0) ? 1 : int'(cnt);
    flips = f;
    for (int i = 0; i < ns; i++) begin
      s = sec + i[5:0];
      lq.push_back({4'H0, 8'H1 << {drv, s[1:0]}, s[5:2]});
    end
    if (wr) begin
      img.delete();
      for (int j = 0; j < ns * 512; j++)
        img.push_back({$urandom, $urandom});
      wq = img;
      repeat (40) @(negedge clk_sys_i);
      cmp_stat({15'H0, hw_ready_o}, 16'H0);
    end else begin
      foreach (img[j])
        dq.push_back({f == 2'H2, img[j]});
    end
    sq.push_back({6'H0, f == 2'H1, f == 2'H2, 8'H00});
    run_cmd({1'H0, wr}, drv, sec, cnt, flaw, dfc, 8'H00);
    if (wr)
      cmp_stat(wcnt[15:0], flaw ? 16'H0202 : 16'H0200);
    $display("Transfer test finished, write %0d", wr);
  endtask
  initial begin
    void'($urandom(41));
    repeat (16) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    sys_rst_i = 0;
    for (int n = 0; n < 8; n++) begin
      sq.push_back({8'H00, 8'H50 + n[7:0]});
      run_cmd(2'H3, n[2], {4'H0, n[1:0]}, 6'H00, 1'H0, 9'H000,
        8'HA0 + n[7:0]);
    end
    $display("Control test finished");
    sq.push_back(16'H0400);
    run_cmd(2'H0, 1'H0, 6'H30, 6'H00, 1'H0, 9'H000, 8'H00);
    sq.push_back(16'H0400);
    run_cmd(2'H1, 1'H1, 6'H2F, 6'H02, 1'H0, 9'H000, 8'H00);
    $display("Refusal test finished");
    iq.push_back({6'H0, 1'H1, 9'H1A5});
    sq.push_back(16'H0000);
    run_cmd(2'H2, 1'H1, 6'H05, 6'H00, 1'H1, 9'H1A5, 8'H00);
    $display("Format test finished");
    xfer(1'H1, 1'H1, 6'H2C, 6'H04, 1'H1, 9'H1FF, 2'H0);
    xfer(1'H0, 1'H1, 6'H2C, 6'H04, 1'H1, 9'H1FF, 2'H0);
    slow = 1;
    xfer(1'H1, 1'H0, 6'H00, 6'H00, 1'H1, 9'H000, 2'H0);
    xfer(1'H0, 1'H0, 6'H00, 6'H00, 1'H1, 9'H000, 2'H1);
    xfer(1'H0, 1'H0, 6'H00, 6'H00, 1'H1, 9'H000, 2'H2);
    complete_run;
  end
  // Tests need about 15k cycles; allow over three times that
  initial begin
    #400000;
    error_cnt++;
    complete_run;
  end
endmodule // testbench
`default_nettype wire
bind sdtc_track_ctrl sdtc_props props (.clk_sys_i, .sys_rst_i, .cmd_valid_i,
  .cmd_op_i, .cmd_sector_i, .cmd_count_i, .cmd_func_i, .cmd_ready_o, .done_o,
  .stat_bad_o, .dk_sel_o, .dk_psec_o, .dk_start_o, .dk_wvalid_o, .dk_wdata_o,
  .dk_wecc_o, .dk_func_valid_o, .dk_func_o, .dk_id_wr_o);
